/* tmc_pkg.sv */
/*
 * tmc_pkg: constants and types for the 8-bit timer/counter with two
 * compare channels.
 * assumes an APB slave with 32-bit data, one register per aligned word.
 */
// Behaviour
// - 8-bit up/down counter, clearable to zero
// - each tick clears, increments or decrements counter
// - 3-bit clock select, zero stops counter
// - cpu reads and writes counter anytime
// - cpu counter write beats clear or count
// - 3-bit waveform mode split across control A/B
// - overflow flag set per mode, interrupt capable
// - equality compare of counter against both registers
// - match sets channel flag one tick later
// - enabled flag raises interrupt, cleared when serviced
// - writing one clears a flag, zero keeps
// - compare double buffered in pwm modes only
// - cpu reaches buffer when buffered, else active
// - force strobe acts like match in non-pwm
// - counter write blocks matches for next tick
// - compare output state survives mode change
// - output action change applies at next match
// - nonzero output action routes compare state to pin
// - compare value visible only when direction is output
// - output action zero leaves state unchanged
// - waveform uses match with top and bottom
// - bottom is 0x00, maximum is 0xff
// - top is maximum or compare A per mode
`default_nettype none
// ================================================================
// package
package tmc_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL_A_OFS = 8'h00;
   localparam logic [7:0] CTRL_B_OFS = 8'h04;
   localparam logic [7:0] COUNT_OFS = 8'h08;
   localparam logic [7:0] CMP_A_OFS = 8'h0c;
   localparam logic [7:0] CMP_B_OFS = 8'h10;
   localparam logic [7:0] FLAG_OFS = 8'h14;
   localparam logic [7:0] MASK_OFS = 8'h18;
   localparam logic [7:0] DDR_OFS = 8'h1c;
   localparam logic [7:0] PORT_OFS = 8'h20;
   // control A: [7:6] action A, [5:4] action B, [1:0] mode low bits
   localparam int ACT_A_POS = 6;
   localparam int ACT_B_POS = 4;
   localparam int WGM_LO_POS = 0;
   // control B: [7] force A, [6] force B, [3] mode bit2, [2:0] clock select
   localparam int FORCE_A_POS = 7;
   localparam int FORCE_B_POS = 6;
   localparam int WGM_HI_POS = 3;
   localparam int CS_POS = 0;
   // flags and mask: [2] match B, [1] match A, [0] overflow
   localparam int FLG_OVF_POS = 0;
   localparam int FLG_A_POS = 1;
   localparam int FLG_B_POS = 2;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] BOTTOM_VAL = 8'h00;
   localparam logic [7:0] MAX_VAL = 8'hff;
   localparam int PRESCALE_BITS = 10;

   typedef struct packed {
      logic [1:0] action_a;
      logic [1:0] action_b;
      logic [2:0] waveform_mode_field;
      logic [2:0] clock_select_field;
   } tmc_cfg_t;
endpackage : tmc_pkg
`default_nettype wire

/* tmc_timer.sv */
/*
 * tmc_timer: 8-bit timer/counter with two compare channels, apb registers
 * and compare output pin override.
 * assumes pins are synchronous to pclk; apb master per the protocol.
 */
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module tmc_timer #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // external count input, already synchronous; sampled into ext_q but no clock select counts it
   input wire logic ext_clk_in,
   // interrupt acknowledge from the controller: bit order as flags
   input wire logic [2:0] irq_ack,
   output logic [2:0] irq_req,
   // compare pins: out and enable; port_q is the plain gpio value
   output logic compare_out_a,
   output logic compare_out_a_oe,
   output logic compare_out_b,
   output logic compare_out_b_oe
);
   // ================================================================
   // apb access
   logic wr_en;
   logic [7:0] wd;
   logic [1:0] act_a_q, act_b_q;
   logic [2:0] wgm_q, cs_q;
   logic [WIDTH-1:0] count_value_reg_q, compare_a_reg_q, compare_b_reg_q;
   logic [WIDTH-1:0] buf_a_q, buf_b_q;
   logic [2:0] flag_q, mask_q;
   logic [1:0] ddr_q, port_q;
   logic oc_a_q, oc_b_q;
   logic block_q;
   logic [tmc_pkg::PRESCALE_BITS-1:0] pre_q;
   logic ext_q;
   logic timer_tick;
   logic pwm_mode, dn_q, top_hit, at_bottom, match_a, match_b;
   logic mpend_a_q, mpend_b_q;
   logic [WIDTH-1:0] top_val;
   logic cnt_wr, force_a, force_b, clr_cyc, ovf_ev;
   tmc_pkg::tmc_cfg_t cfg;

   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign wr_en = psel && penable && pwrite;
   assign wd = pwdata[7:0];
   assign cnt_wr = wr_en && (paddr == tmc_pkg::COUNT_OFS);
   // strobes exist only in the write cycle; nothing stores them
   assign force_a = wr_en && (paddr == tmc_pkg::CTRL_B_OFS) && wd[tmc_pkg::FORCE_A_POS]
      && !pwm_mode;
   assign force_b = wr_en && (paddr == tmc_pkg::CTRL_B_OFS) && wd[tmc_pkg::FORCE_B_POS]
      && !pwm_mode;
   assign cfg = '{act_a_q, act_b_q, wgm_q, cs_q};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         act_a_q <= 2'h0;
         act_b_q <= 2'h0;
         wgm_q <= 3'h0;
         cs_q <= 3'h0;
         mask_q <= 3'h0;
         ddr_q <= 2'h0;
         port_q <= 2'h0;
      end
      else if (wr_en)
      begin
         if (paddr == tmc_pkg::CTRL_A_OFS)
         begin
            act_a_q <= wd[tmc_pkg::ACT_A_POS +: 2];
            act_b_q <= wd[tmc_pkg::ACT_B_POS +: 2];
            wgm_q[1:0] <= wd[tmc_pkg::WGM_LO_POS +: 2];
         end
         if (paddr == tmc_pkg::CTRL_B_OFS)
         begin
            wgm_q[2] <= wd[tmc_pkg::WGM_HI_POS];
            cs_q <= wd[tmc_pkg::CS_POS +: 3];
         end
         if (paddr == tmc_pkg::MASK_OFS)
            mask_q <= wd[2:0];
         if (paddr == tmc_pkg::DDR_OFS)
            ddr_q <= wd[1:0];
         if (paddr == tmc_pkg::PORT_OFS)
            port_q <= wd[1:0];
      end
   end

   always_comb
   begin
      prdata = 32'h0000_0000;
      unique case (paddr)
         tmc_pkg::CTRL_A_OFS: prdata[7:0] = {cfg.action_a, cfg.action_b, 2'h0,
            cfg.waveform_mode_field[1:0]};
         // force strobes are never stored, so their places read zero
         tmc_pkg::CTRL_B_OFS: prdata[7:0] = {4'h0, cfg.waveform_mode_field[2],
            cfg.clock_select_field};
         tmc_pkg::COUNT_OFS: prdata[7:0] = count_value_reg_q;
         tmc_pkg::CMP_A_OFS: prdata[7:0] = pwm_mode ? buf_a_q : compare_a_reg_q;
         tmc_pkg::CMP_B_OFS: prdata[7:0] = pwm_mode ? buf_b_q : compare_b_reg_q;
         tmc_pkg::FLAG_OFS: prdata[2:0] = flag_q;
         tmc_pkg::MASK_OFS: prdata[2:0] = mask_q;
         tmc_pkg::DDR_OFS: prdata[1:0] = ddr_q;
         tmc_pkg::PORT_OFS: prdata[1:0] = port_q;
         default: prdata = 32'h0000_0000;
      endcase
   end

   // ================================================================
   // clock select and prescaler
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pre_q <= '0;
         ext_q <= 1'b0;
      end
      else
      begin
         pre_q <= pre_q + 1'b1;
         ext_q <= ext_clk_in;
      end
   end

   always_comb
   begin
      unique case (cs_q)
         3'h0: timer_tick = 1'b0;
         3'h1: timer_tick = 1'b1;
         3'h2: timer_tick = &pre_q[2:0];
         3'h3: timer_tick = &pre_q[4:0];
         3'h4: timer_tick = &pre_q[5:0];
         3'h5: timer_tick = &pre_q[6:0];
         3'h6: timer_tick = &pre_q[7:0];
         3'h7: timer_tick = &pre_q;
      endcase
   end

   // ================================================================
   // counter unit
   // modes: 0 normal, 2 ctc, 1/5 phase correct, 3/7 fast pwm; 4/6 treated as normal
   assign pwm_mode = (wgm_q[1:0] == 2'h1) || (wgm_q[1:0] == 2'h3);
   assign top_val = wgm_q[2] || (wgm_q == 3'h2) ? compare_a_reg_q : tmc_pkg::MAX_VAL;
   assign top_hit = count_value_reg_q == top_val;
   assign at_bottom = count_value_reg_q == tmc_pkg::BOTTOM_VAL;
   // ctc clears on match with compare A, fast pwm clears after top
   assign clr_cyc = top_hit && ((wgm_q[1:0] == 2'h3) || (wgm_q == 3'h2));
   assign ovf_ev = timer_tick && !cnt_wr && (wgm_q[1:0] == 2'h1 ? at_bottom && dn_q
      : (wgm_q[1:0] == 2'h3 ? top_hit : count_value_reg_q == tmc_pkg::MAX_VAL));

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         count_value_reg_q <= '0;
         dn_q <= 1'b0;
      end
      else if (cnt_wr)
         count_value_reg_q <= wd;
      else if (timer_tick)
      begin
         if (wgm_q[1:0] == 2'h1)
         begin
            if (top_hit)
               dn_q <= 1'b1;
            else if (at_bottom)
               dn_q <= 1'b0;
            if (top_hit || (!dn_q && !at_bottom))
               count_value_reg_q <= (top_hit ? count_value_reg_q - 1'b1
                  : count_value_reg_q + 1'b1);
            else
               count_value_reg_q <= at_bottom ? count_value_reg_q + 1'b1
                  : count_value_reg_q - 1'b1;
         end
         else if (clr_cyc)
            count_value_reg_q <= '0;
         else
         begin
            dn_q <= 1'b0;
            count_value_reg_q <= count_value_reg_q + 1'b1;
         end
      end
   end

   // ================================================================
   // compare registers with double buffer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         compare_a_reg_q <= '0;
         compare_b_reg_q <= '0;
         buf_a_q <= '0;
         buf_b_q <= '0;
      end
      else
      begin
         if (wr_en && paddr == tmc_pkg::CMP_A_OFS)
            buf_a_q <= wd;
         if (wr_en && paddr == tmc_pkg::CMP_B_OFS)
            buf_b_q <= wd;
         if (!pwm_mode)
         begin
            // buffer bypassed: cpu writes land in the active register
            if (wr_en && paddr == tmc_pkg::CMP_A_OFS)
               compare_a_reg_q <= wd;
            if (wr_en && paddr == tmc_pkg::CMP_B_OFS)
               compare_b_reg_q <= wd;
         end
         else if (timer_tick && (wgm_q[1:0] == 2'h1 ? top_hit : clr_cyc))
         begin
            // load at top (phase correct) or on the wrap to bottom (fast pwm)
            compare_a_reg_q <= buf_a_q;
            compare_b_reg_q <= buf_b_q;
         end
      end
   end

   // ================================================================
   // comparator, flags and output state
   assign match_a = (count_value_reg_q == compare_a_reg_q) && !block_q;
   assign match_b = (count_value_reg_q == compare_b_reg_q) && !block_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         block_q <= 1'b0;
      else if (cnt_wr)
         block_q <= 1'b1;
      else if (timer_tick)
         block_q <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mpend_a_q <= 1'b0;
         mpend_b_q <= 1'b0;
      end
      else if (timer_tick)
      begin
         mpend_a_q <= match_a;
         mpend_b_q <= match_b;
      end
   end

   // flag set one tick after the match is seen; a set beats any clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flag_q <= 3'h0;
      else
      begin
         for (int i = 0; i < 3; i++)
         begin
            if ((wr_en && paddr == tmc_pkg::FLAG_OFS && wd[i]) || irq_ack[i])
               flag_q[i] <= 1'b0;
         end
         if (ovf_ev)
            flag_q[tmc_pkg::FLG_OVF_POS] <= 1'b1;
         if (timer_tick && mpend_a_q)
            flag_q[tmc_pkg::FLG_A_POS] <= 1'b1;
         if (timer_tick && mpend_b_q)
            flag_q[tmc_pkg::FLG_B_POS] <= 1'b1;
      end
   end

   assign irq_req = flag_q & mask_q;

   // next output state for one channel; zero action keeps it
   function automatic logic oc_next(input logic cur, input logic [1:0] act,
      input logic pwm, input logic hit, input logic wrap);
      logic r;
      r = cur;
      if (act == 2'h1 && hit)
         r = !cur;
      else if (!pwm && act[1] && hit)
         r = act[0];
      else if (pwm && act[1] && hit)
         r = act[0];
      else if (pwm && act[1] && wrap)
         r = !act[0];
      return r;
   endfunction : oc_next

   logic hit_a, hit_b, wrap_cyc;
   // fast pwm restores at bottom; phase correct acts only on matches while counting up
   assign wrap_cyc = timer_tick && (wgm_q[1:0] == 2'h3) && clr_cyc;
   assign hit_a = (timer_tick && match_a && !(wgm_q[1:0] == 2'h1 && dn_q)) || force_a;
   assign hit_b = (timer_tick && match_b && !(wgm_q[1:0] == 2'h1 && dn_q)) || force_b;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         oc_a_q <= 1'b0;
         oc_b_q <= 1'b0;
      end
      else
      begin
         // only matches, forces and the fast pwm wrap to bottom move it; a mode change alone never does
         oc_a_q <= oc_next(oc_a_q, act_a_q, pwm_mode, hit_a, wrap_cyc);
         oc_b_q <= oc_next(oc_b_q, act_b_q, pwm_mode, hit_b, wrap_cyc);
      end
   end

   // ================================================================
   // pin override
   assign compare_out_a = (|act_a_q) ? oc_a_q : port_q[0];
   assign compare_out_b = (|act_b_q) ? oc_b_q : port_q[1];
   assign compare_out_a_oe = ddr_q[0];
   assign compare_out_b_oe = ddr_q[1];

   // ================================================================
   // checks
   counter_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      cnt_wr |=> count_value_reg_q == $past(wd)) else $error("counter write lost");
   stop_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      (cs_q == 3'h0 && !cnt_wr) |=> $stable(count_value_reg_q))
      else $error("counter moved while stopped");
   flag_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
      (timer_tick && mpend_a_q && !flag_q[1]) |=> flag_q[1]) else $error("flag A not set");
   flag_b_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
      (timer_tick && mpend_b_q && !flag_q[2]) |=> flag_q[2]) else $error("flag B not set");
   block_match_a: assert property (@(posedge pclk) disable iff (!presetn)
      $past(cnt_wr) |-> !match_a && !match_b) else $error("match not blocked");
   flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == tmc_pkg::FLAG_OFS && wd[1] && !(timer_tick && mpend_a_q))
      |=> !flag_q[1]) else $error("flag A not cleared");
   ovf_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      ovf_ev |=> flag_q[tmc_pkg::FLG_OVF_POS]) else $error("overflow flag not set");
   tick_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      (timer_tick && !cnt_wr && clr_cyc) |=> count_value_reg_q == tmc_pkg::BOTTOM_VAL)
      else $error("counter not cleared at top");
   act_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      (act_a_q == 2'h0) |=> oc_a_q == $past(oc_a_q)) else $error("state changed");
   pin_route_a: assert property (@(posedge pclk) disable iff (!presetn)
      (act_b_q != 2'h0) |-> compare_out_b == oc_b_q) else $error("pin not routed");
   pin_source_a: assert property (@(posedge pclk) disable iff (!presetn)
      (act_a_q != 2'h0) |-> compare_out_a == oc_a_q) else $error("pin A not routed");
   buf_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      (pwm_mode && !timer_tick) |=> $stable(compare_a_reg_q))
      else $error("active compare changed");
   force_noflag_a: assert property (@(posedge pclk) disable iff (!presetn)
      (force_a && !flag_q[1] && !(timer_tick && mpend_a_q)) |=> !flag_q[1])
      else $error("force set flag");
   force_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
      (force_a && act_a_q == 2'h3) |=> oc_a_q) else $error("force did not set output");
endmodule : tmc_timer
`default_nettype wire

/* tb_top.sv */
/*
 * tb_top: self-checking bench for tmc_timer, driven over apb.
 * assumes output action 1 toggles, 2 clears, 3 sets in non-pwm modes.
 */
`timescale 1ns/100ps
`default_nettype none
// ================================================================
// bench
module tb_top;
   logic pclk, presetn, psel, penable, pwrite, ext_clk_in, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, c0;
   logic [2:0] irq_ack, irq_req;
   logic oa, oa_oe, ob, ob_oe;
   logic [1:0] act;
   int fail_count, check_count;

   tmc_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_clk_in(ext_clk_in),
      .irq_ack(irq_ack), .irq_req(irq_req), .compare_out_a(oa),
      .compare_out_a_oe(oa_oe), .compare_out_b(ob), .compare_out_b_oe(ob_oe));

   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task give_verdict;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict

   // one transfer; request held until pready is seen high
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         fail_count++;
         give_verdict();
      end
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask : rdchk

   function automatic logic [31:0] ctl_b(input logic f, input logic [2:0] m,
         input logic [2:0] cs);
      return (32'(f) << tmc_pkg::FORCE_A_POS) | (32'(m[2]) << tmc_pkg::WGM_HI_POS) | 32'(cs);
   endfunction : ctl_b

   task set_mode(input logic [2:0] m);
      wr(tmc_pkg::CTRL_A_OFS, (32'(act) << tmc_pkg::ACT_A_POS) | 32'(m[1:0]));
      wr(tmc_pkg::CTRL_B_OFS, ctl_b(1'b0, m, 3'h0));
   endtask : set_mode

   // every-pclk tick for at least n cycles, then stop
   task run(input logic [2:0] m, input int n);
      wr(tmc_pkg::CTRL_B_OFS, ctl_b(1'b0, m, 3'h1));
      repeat (n) @(posedge pclk);
      wr(tmc_pkg::CTRL_B_OFS, ctl_b(1'b0, m, 3'h0));
   endtask : run

   task force_a(input logic [1:0] ac, input logic exp);
      act = ac;
      set_mode(3'h0);
      wr(tmc_pkg::CTRL_B_OFS, ctl_b(1'b1, 3'h0, 3'h0));
      repeat (2) @(posedge pclk);
      check({31'h0, oa}, {31'h0, exp});
   endtask : force_a

   initial
   begin
      {psel, penable, pwrite, ext_clk_in} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      irq_ack = 3'h0;
      act = 2'h0;
      fail_count = 0;
      check_count = 0;
      presetn = 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      // ================================================================
      // reset values and unmapped place
      for (int a = 0; a <= 'h24; a += 4)
         rdchk(8'(a), 32'h0);
      wr(8'h24, 32'h5a);
      rdchk(8'h24, 32'h0);
      check({30'h0, pready, pslverr}, 32'h2);
      $display("test reset done");
      // ================================================================
      // counter access and counting
      wr(tmc_pkg::COUNT_OFS, 32'h5a);
      repeat (5) @(posedge pclk);
      rdchk(tmc_pkg::COUNT_OFS, 32'h5a);
      wr(tmc_pkg::COUNT_OFS, 32'h0);
      run(3'h0, 0);
      apb(1'b0, tmc_pkg::COUNT_OFS, 32'h0);
      check(32'(rd >= 1 && rd <= 6), 32'h1);
      wr(tmc_pkg::CTRL_B_OFS, ctl_b(1'b0, 3'h0, 3'h1));
      wr(tmc_pkg::COUNT_OFS, 32'h80);
      wr(tmc_pkg::CTRL_B_OFS, ctl_b(1'b0, 3'h0, 3'h0));
      apb(1'b0, tmc_pkg::COUNT_OFS, 32'h0);
      check(32'(rd >= 32'h80 && rd <= 32'h86), 32'h1);
      set_mode(3'h1);
      wr(tmc_pkg::COUNT_OFS, 32'hfd);
      run(3'h1, 8);
      apb(1'b0, tmc_pkg::COUNT_OFS, 32'h0);
      check(32'(rd >= 32'hf0 && rd < 32'hfd), 32'h1);
      set_mode(3'h2);
      wr(tmc_pkg::CMP_A_OFS, 32'h05);
      wr(tmc_pkg::COUNT_OFS, 32'h0);
      run(3'h2, 40);
      apb(1'b0, tmc_pkg::COUNT_OFS, 32'h0);
      check(32'(rd <= 32'h05), 32'h1);
      $display("test counter done");
      // ================================================================
      // flags, interrupts, clearing
      set_mode(3'h0);
      wr(tmc_pkg::CMP_A_OFS, 32'hf8);
      wr(tmc_pkg::CMP_B_OFS, 32'h03);
      wr(tmc_pkg::COUNT_OFS, 32'hf0);
      wr(tmc_pkg::FLAG_OFS, 32'h7);
      run(3'h0, 30);
      rdchk(tmc_pkg::FLAG_OFS, 32'h7);
      wr(tmc_pkg::MASK_OFS, 32'h7);
      repeat (2) @(posedge pclk);
      check({29'h0, irq_req}, 32'h7);
      irq_ack <= 3'h2;
      @(posedge pclk);
      irq_ack <= 3'h0;
      repeat (2) @(posedge pclk);
      check({29'h0, irq_req}, 32'h5);
      wr(tmc_pkg::FLAG_OFS, 32'h1);
      rdchk(tmc_pkg::FLAG_OFS, 32'h4);
      wr(tmc_pkg::FLAG_OFS, 32'h0);
      rdchk(tmc_pkg::FLAG_OFS, 32'h4);
      $display("test flags done");
      // ================================================================
      // match blocked by counter write, then not blocked
      wr(tmc_pkg::CMP_A_OFS, 32'h10);
      wr(tmc_pkg::CMP_B_OFS, 32'h10);
      wr(tmc_pkg::COUNT_OFS, 32'h10);
      wr(tmc_pkg::FLAG_OFS, 32'h7);
      run(3'h0, 3);
      rdchk(tmc_pkg::FLAG_OFS, 32'h0);
      wr(tmc_pkg::COUNT_OFS, 32'h0f);
      run(3'h0, 3);
      rdchk(tmc_pkg::FLAG_OFS, 32'h6);
      $display("test blocking done");
      // ================================================================
      // compare buffering in pwm modes only
      wr(tmc_pkg::CMP_A_OFS, 32'h20);
      set_mode(3'h3);
      wr(tmc_pkg::CMP_A_OFS, 32'h40);
      rdchk(tmc_pkg::CMP_A_OFS, 32'h40);
      wr(tmc_pkg::COUNT_OFS, 32'h3e);
      wr(tmc_pkg::FLAG_OFS, 32'h7);
      run(3'h3, 3);
      apb(1'b0, tmc_pkg::FLAG_OFS, 32'h0);
      check({31'h0, rd[1]}, 32'h0);
      set_mode(3'h0);
      wr(tmc_pkg::CMP_A_OFS, 32'h40);
      wr(tmc_pkg::COUNT_OFS, 32'h3e);
      wr(tmc_pkg::FLAG_OFS, 32'h7);
      run(3'h0, 3);
      apb(1'b0, tmc_pkg::FLAG_OFS, 32'h0);
      check({31'h0, rd[1]}, 32'h1);
      $display("test buffering done");
      // ================================================================
      // forced compare and pin override
      wr(tmc_pkg::FLAG_OFS, 32'h7);
      wr(tmc_pkg::DDR_OFS, 32'h1);
      repeat (2) @(posedge pclk);
      check({31'h0, oa_oe}, 32'h1);
      apb(1'b0, tmc_pkg::COUNT_OFS, 32'h0);
      c0 = rd;
      force_a(2'h3, 1'b1);
      rdchk(tmc_pkg::CTRL_B_OFS, 32'h0);
      rdchk(tmc_pkg::FLAG_OFS, 32'h0);
      rdchk(tmc_pkg::COUNT_OFS, c0);
      force_a(2'h2, 1'b0);
      force_a(2'h3, 1'b1);
      wr(tmc_pkg::PORT_OFS, 32'h0);
      act = 2'h0;
      set_mode(3'h0);
      wr(tmc_pkg::CTRL_B_OFS, ctl_b(1'b1, 3'h0, 3'h0));
      force_a(2'h1, 1'b0);
      force_a(2'h1, 1'b1);
      set_mode(3'h3);
      repeat (2) @(posedge pclk);
      check({31'h0, oa}, 32'h1);
      act = 2'h0;
      set_mode(3'h3);
      wr(tmc_pkg::PORT_OFS, 32'h0);
      repeat (2) @(posedge pclk);
      check({31'h0, oa}, 32'h0);
      wr(tmc_pkg::CTRL_A_OFS, 32'h3 << tmc_pkg::ACT_B_POS);
      wr(tmc_pkg::CTRL_B_OFS, 32'h1 << tmc_pkg::FORCE_B_POS);
      wr(tmc_pkg::DDR_OFS, 32'h2);
      repeat (2) @(posedge pclk);
      check({30'h0, ob, ob_oe}, 32'h3);
      wr(tmc_pkg::DDR_OFS, 32'h0);
      repeat (2) @(posedge pclk);
      check({30'h0, oa_oe, ob_oe}, 32'h0);
      $display("test outputs done");
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
